// ==== verilog/memory_timing_config.sv ====
/*
  memory timing configuration slice: registers, buffer control pair,
  parity mode, open-page retention, refresh recovery, read latency and
  dram/edo cas and ras timers. assumes the controller core drives the
  event struct synchronously on clk_in and obeys the timer outputs.
*/
`timescale 1ns/10ps
module memory_timing_config
  import mem_timing_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic [7:0]           addr_in,
  input  wire logic [31:0]          wr_data_in,
  input  wire logic                 wr_strobe_in,
  input  wire logic                 rd_strobe_in,
  output logic [31:0]               rd_data_out,
  input  mem_timing_pkg::mem_evt_t  evt_in,
  output logic                      buffer_ctrl_a_out,
  output logic                      buffer_ctrl_b_out,
  output logic                      rmw_parity_enable_out,
  output logic                      parity_gen_enable_out,
  output logic                      precharge_cmd_out,
  output logic                      activate_allowed_out,
  output logic                      first_beat_out,
  output logic                      ras_refresh_out,
  output logic                      cas_active_out,
  output logic                      cas_ready_out
);
  import mem_timing_pkg::*;

  function automatic logic [TIMER_W-1:0] decode4(input logic [3:0] code);
    decode4 = (code == 4'h0) ? 5'h10 : {1'b0, code};
  endfunction

  function automatic logic [TIMER_W-1:0] decode3(input logic [2:0] code);
    decode3 = (code == 3'h0) ? 5'h08 : {2'h0, code};
  endfunction

  // register file
  logic [31:0] cfg_two_q;
  logic [31:0] cfg_two_d;
  logic [31:0] cfg_three_q;
  logic [31:0] cfg_three_d;
  logic [31:0] cfg_aux_q;
  logic [31:0] cfg_aux_d;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic [31:0] status_w;

  always_comb
  begin
    cfg_two_d   = cfg_two_q;
    cfg_three_d = cfg_three_q;
    cfg_aux_d   = cfg_aux_q;
    rd_data_d   = 32'h0000_0000;
    if (wr_strobe_in)
    begin
      unique case (addr_in)
        OFF_CFG_TWO:   cfg_two_d   = wr_data_in & MASK_CFG_TWO;
        OFF_CFG_THREE: cfg_three_d = wr_data_in & MASK_CFG_THREE;
        OFF_CFG_AUX:   cfg_aux_d   = wr_data_in & MASK_CFG_AUX;
        default:       cfg_aux_d   = cfg_aux_q;
      endcase
    end
    if (rd_strobe_in)
    begin
      unique case (addr_in)
        OFF_CFG_TWO:   rd_data_d = cfg_two_q;
        OFF_CFG_THREE: rd_data_d = cfg_three_q;
        OFF_CFG_AUX:   rd_data_d = cfg_aux_q;
        OFF_STATUS:    rd_data_d = status_w;
        default:       rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg_two_q   <= RST_CFG_TWO;
      cfg_three_q <= RST_CFG_THREE;
      cfg_aux_q   <= RST_CFG_AUX;
      rd_data_q   <= 32'h0000_0000;
    end
    else
    begin
      cfg_two_q   <= cfg_two_d;
      cfg_three_q <= cfg_three_d;
      cfg_aux_q   <= cfg_aux_d;
      rd_data_q   <= rd_data_d;
    end
  end

  assign rd_data_out = rd_data_q;

  // field views
  logic                   sdram_w;
  logic                   buf_mode_w;
  logic [OPEN_PAGE_W-1:0] open_page_interval;
  logic [3:0]             refresh_to_activate;
  logic [3:0]             read_data_latency;
  logic                   cas_write_modifier;
  logic [3:0]             refresh_ras_width;
  logic [2:0]             page_cas_width;
  logic [2:0]             cas_precharge_count;

  always_comb
  begin
    sdram_w             = cfg_aux_q[POS_SDRAM];
    buf_mode_w          = cfg_two_q[POS_BUF_MODE];
    open_page_interval  = {cfg_two_q[POS_OPI_LO +: 2], cfg_three_q[POS_OPI_MID +: 4],
                           cfg_aux_q[POS_OPI_HI +: 4]};
    refresh_to_activate = cfg_three_q[POS_REF_ACT +: 4];
    read_data_latency   = cfg_three_q[POS_READ_LAT +: 4];
    cas_write_modifier  = cfg_three_q[POS_CAS_WMOD];
    refresh_ras_width   = cfg_three_q[POS_RAS_WIDTH +: 4];
    page_cas_width      = cfg_three_q[POS_PAGE_CAS +: 3];
    cas_precharge_count = cfg_three_q[POS_CAS_PRE +: 3];
  end

  // sdram timers
  logic [OPEN_PAGE_W-1:0]  page_ctr_q;
  logic [OPEN_PAGE_W-1:0]  page_ctr_d;
  logic                    page_open_q;
  logic                    page_open_d;
  logic                    precharge_q;
  logic                    precharge_d;
  logic [TIMER_W-1:0]      ref_ctr_q;
  logic [TIMER_W-1:0]      ref_ctr_d;
  logic                    act_ok_q;
  logic                    act_ok_d;
  logic [READ_LAT_MAX-1:0] lat_pipe_q;
  logic [READ_LAT_MAX-1:0] lat_pipe_d;

  always_comb
  begin
    page_ctr_d  = page_ctr_q;
    page_open_d = page_open_q;
    precharge_d = 1'b0;
    ref_ctr_d   = (ref_ctr_q != 5'h00) ? ref_ctr_q - 5'h01 : ref_ctr_q;
    lat_pipe_d  = lat_pipe_q >> 1;
    if (sdram_w)
    begin
      if (evt_in.page_access)
      begin
        page_ctr_d  = open_page_interval;
        page_open_d = 1'b1;
      end
      else if (page_open_q)
      begin
        if (page_ctr_q == '0)
        begin
          precharge_d = 1'b1;
          page_open_d = 1'b0;
        end
        else
        begin
          page_ctr_d = page_ctr_q - 10'h001;
        end
      end
      if (evt_in.refresh_cmd)
      begin
        ref_ctr_d = decode4(refresh_to_activate) - 5'h01;
      end
      if (evt_in.read_cmd && read_data_latency != 4'h0
          && read_data_latency <= 4'(READ_LAT_MAX))
      begin
        lat_pipe_d[3'(read_data_latency - 4'h1)] = 1'b1;
      end
    end
    else
    begin
      page_open_d = 1'b0;
      ref_ctr_d   = 5'h00;
    end
    act_ok_d = (ref_ctr_d == 5'h00);
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      page_ctr_q  <= '0;
      page_open_q <= 1'b0;
      precharge_q <= 1'b0;
      ref_ctr_q   <= 5'h00;
      act_ok_q    <= 1'b1;
      lat_pipe_q  <= '0;
    end
    else
    begin
      page_ctr_q  <= page_ctr_d;
      page_open_q <= page_open_d;
      precharge_q <= precharge_d;
      ref_ctr_q   <= ref_ctr_d;
      act_ok_q    <= act_ok_d;
      lat_pipe_q  <= lat_pipe_d;
    end
  end

  assign precharge_cmd_out    = precharge_q;
  assign activate_allowed_out = act_ok_q;
  assign first_beat_out       = lat_pipe_q[0];

  // dram/edo timers
  cas_state_t         cas_state_q;
  cas_state_t         cas_state_d;
  logic [TIMER_W-1:0] cas_ctr_q;
  logic [TIMER_W-1:0] cas_ctr_d;
  logic               cas_wr_q;
  logic               cas_wr_d;
  logic [TIMER_W-1:0] ras_ctr_q;
  logic [TIMER_W-1:0] ras_ctr_d;
  logic [TIMER_W-1:0] cas_on_len;
  logic [TIMER_W-1:0] cas_off_len;
  logic               ras_on_q;
  logic               ras_on_d;

  always_comb
  begin
    cas_state_d = cas_state_q;
    cas_ctr_d   = cas_ctr_q;
    cas_wr_d    = cas_wr_q;
    ras_ctr_d   = (ras_ctr_q != 5'h00) ? ras_ctr_q - 5'h01 : ras_ctr_q;
    cas_on_len  = decode3(page_cas_width);
    cas_off_len = decode3(cas_precharge_count);
    if (cas_write_modifier && evt_in.page_cycle_write && cas_on_len > 5'h01)
    begin
      cas_on_len = cas_on_len - 5'h01;
    end
    if (cas_write_modifier && cas_wr_q)
    begin
      cas_off_len = cas_off_len + 5'h01;
    end
    if (!sdram_w && evt_in.cbr_start)
    begin
      ras_ctr_d = decode4(refresh_ras_width);
    end
    ras_on_d = (ras_ctr_d != 5'h00);
    unique case (cas_state_q)
      CAS_IDLE:
      begin
        if (!sdram_w && evt_in.page_cycle_start)
        begin
          cas_state_d = CAS_ASSERT;
          cas_ctr_d   = cas_on_len;
          cas_wr_d    = evt_in.page_cycle_write;
        end
      end
      CAS_ASSERT:
      begin
        if (cas_ctr_q <= 5'h01)
        begin
          cas_state_d = CAS_PRECHG;
          cas_ctr_d   = cas_off_len;
        end
        else
        begin
          cas_ctr_d = cas_ctr_q - 5'h01;
        end
      end
      CAS_PRECHG:
      begin
        if (cas_ctr_q <= 5'h01)
        begin
          cas_state_d = CAS_IDLE;
          cas_ctr_d   = 5'h00;
        end
        else
        begin
          cas_ctr_d = cas_ctr_q - 5'h01;
        end
      end
      default:
      begin
        cas_state_d = CAS_IDLE;
        cas_ctr_d   = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cas_state_q <= CAS_IDLE;
      cas_ctr_q   <= 5'h00;
      cas_wr_q    <= 1'b0;
      ras_ctr_q   <= 5'h00;
      ras_on_q    <= 1'b0;
    end
    else
    begin
      cas_state_q <= cas_state_d;
      cas_ctr_q   <= cas_ctr_d;
      cas_wr_q    <= cas_wr_d;
      ras_ctr_q   <= ras_ctr_d;
      ras_on_q    <= ras_on_d;
    end
  end

  // state codes chosen so each cas flag is a single state bit
  assign ras_refresh_out = ras_on_q;
  assign cas_active_out  = cas_state_q[1];
  assign cas_ready_out   = cas_state_q[0];

  // buffer control and parity outputs
  logic buf_a_q;
  logic buf_a_d;
  logic buf_b_q;
  logic buf_b_d;
  logic rmw_q;
  logic rmw_d;
  logic par_gen_q;
  logic par_gen_d;

  always_comb
  begin
    if (buf_mode_w)
    begin
      buf_a_d = evt_in.buf_read;
      buf_b_d = evt_in.buf_read | evt_in.buf_write;
    end
    else
    begin
      buf_a_d = evt_in.buf_write;
      buf_b_d = evt_in.buf_read;
    end
    rmw_d     = cfg_two_q[POS_RMW_PARITY];
    par_gen_d = cfg_aux_q[POS_PAR_CHECK] & ~cfg_two_q[POS_ECC_EN];
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      buf_a_q   <= 1'b0;
      buf_b_q   <= 1'b0;
      rmw_q     <= 1'b0;
      par_gen_q <= 1'b0;
    end
    else
    begin
      buf_a_q   <= buf_a_d;
      buf_b_q   <= buf_b_d;
      rmw_q     <= rmw_d;
      par_gen_q <= par_gen_d;
    end
  end

  assign buffer_ctrl_a_out     = buf_a_q;
  assign buffer_ctrl_b_out     = buf_b_q;
  assign rmw_parity_enable_out = rmw_q;
  assign parity_gen_enable_out = par_gen_q;

  assign status_w = {28'h000_0000, ras_refresh_out, ~cas_ready_out, ~act_ok_q, page_open_q};

endmodule

// ==== verilog/mem_timing_pkg.sv ====
/*
  constants, register layout and carrier types for the memory timing
  configuration slice. assumes one 25 MHz clock shared with the memory
  controller core.
*/
package mem_timing_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  localparam logic [7:0] OFF_CFG_TWO    = 8'hf4;
  localparam logic [7:0] OFF_CFG_THREE  = 8'hf8;
  localparam logic [7:0] OFF_CFG_AUX    = 8'hfc;
  localparam logic [7:0] OFF_STATUS     = 8'h00;

  localparam logic [31:0] RST_CFG_TWO   = 32'h0000_0002;
  localparam logic [31:0] RST_CFG_THREE = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_AUX   = 32'h0000_0000;
  localparam logic [31:0] MASK_CFG_TWO  = 32'he03f_ffff;
  localparam logic [31:0] MASK_CFG_THREE = 32'hffff_ffff;
  localparam logic [31:0] MASK_CFG_AUX  = 32'h0000_030f;

  // cfg_two fields
  localparam int unsigned POS_RMW_PARITY  = 0;
  localparam int unsigned POS_BUF_MODE    = 1;
  localparam int unsigned POS_EDO         = 16;
  localparam int unsigned POS_ECC_EN      = 17;
  localparam int unsigned POS_OPI_LO      = 20;
  // cfg_three fields
  localparam int unsigned POS_CAS_PRE     = 9;
  localparam int unsigned POS_PAGE_CAS    = 12;
  localparam int unsigned POS_RAS_WIDTH   = 15;
  localparam int unsigned POS_CAS_WMOD    = 19;
  localparam int unsigned POS_READ_LAT    = 20;
  localparam int unsigned POS_REF_ACT     = 24;
  localparam int unsigned POS_OPI_MID     = 28;
  // cfg_aux fields
  localparam int unsigned POS_OPI_HI      = 0;
  localparam int unsigned POS_PAR_CHECK   = 8;
  localparam int unsigned POS_SDRAM       = 9;

  localparam int unsigned OPEN_PAGE_W     = 10;
  localparam int unsigned READ_LAT_MAX    = 5;
  localparam int unsigned TIMER_W         = 5;

  typedef enum logic [1:0]
  {
    CAS_IDLE   = 2'b01,
    CAS_ASSERT = 2'b10,
    CAS_PRECHG = 2'b00
  } cas_state_t;

  // one-cycle requests from the controller core
  typedef struct packed
  {
    logic page_access;
    logic refresh_cmd;
    logic read_cmd;
    logic cbr_start;
    logic page_cycle_start;
    logic page_cycle_write;
    logic buf_write;
    logic buf_read;
  } mem_evt_t;

endpackage

// ==== bench/mtc_chk.sv ====
/* checker: shadow registers and timers rebuilt from the ports.
   assumes one clock domain, bound to memory_timing_config below. */
`timescale 1ns/10ps
module mtc_chk
  import mem_timing_pkg::*;
(
  input wire logic                      clk_in,
  input wire logic                      reset_n_in,
  input wire logic [7:0]                addr_in,
  input wire logic [31:0]               wr_data_in,
  input wire logic                      wr_strobe_in,
  input wire logic                      rd_strobe_in,
  input wire logic [31:0]               rd_data_out,
  input wire mem_timing_pkg::mem_evt_t  evt_in,
  input wire logic                      buffer_ctrl_a_out,
  input wire logic                      buffer_ctrl_b_out,
  input wire logic                      rmw_parity_enable_out,
  input wire logic                      precharge_cmd_out,
  input wire logic                      activate_allowed_out,
  input wire logic                      first_beat_out,
  input wire logic                      ras_refresh_out,
  input wire logic                      cas_active_out,
  input wire logic                      cas_ready_out
);
  logic [31:0] c2_q, c3_q, ax_q;
  logic [4:0]  rc_q, rr_q, sh_q;
  logic [9:0]  pc_q;
  logic        on_q, ex_q, sd;
  assign sd = ax_q[POS_SDRAM];
  function automatic logic [4:0] n16(input logic [3:0] c);
    return (c == 4'h0) ? 5'h10 : {1'b0, c};
  endfunction
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      c2_q <= 32'h0000_0002;
      {c3_q, ax_q, rc_q, rr_q, sh_q, pc_q, on_q, ex_q} <= '0;
    end
    else
    begin
      if (wr_strobe_in && addr_in == OFF_CFG_TWO)
        c2_q <= wr_data_in;
      if (wr_strobe_in && addr_in == OFF_CFG_THREE)
        c3_q <= wr_data_in;
      if (wr_strobe_in && addr_in == OFF_CFG_AUX)
        ax_q <= wr_data_in;
      sh_q <= {sh_q[3:0], evt_in.read_cmd && sd};
      rc_q <= !sd ? 5'h0 : evt_in.refresh_cmd ? n16(c3_q[27:24]) - 5'h1 : rc_q - 5'(rc_q != 5'h0);
      rr_q <= (evt_in.cbr_start && !sd) ? n16(c3_q[18:15]) : rr_q - 5'(rr_q != 5'h0);
      ex_q <= sd && on_q && pc_q == 10'h0 && !evt_in.page_access;
      if (!sd)
        on_q <= 1'b0;
      else if (evt_in.page_access)
      begin
        pc_q <= {c2_q[21:20], c3_q[31:28], ax_q[3:0]};
        on_q <= 1'b1;
      end
      else if (on_q)
      begin
        pc_q <= pc_q - 10'(pc_q != 10'h0);
        on_q <= pc_q != 10'h0;
      end
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  chk_rd_zero: assert property (!$past(rd_strobe_in) |-> rd_data_out == 32'h0)
    else $error("read data not zero");
  chk_buf_pair: assert property ($past(evt_in.buf_read ^ evt_in.buf_write) |->
    {buffer_ctrl_a_out, buffer_ctrl_b_out} == ($past(c2_q[POS_BUF_MODE]) ? {$past(evt_in.buf_read), 1'b1}
    : {$past(evt_in.buf_write), $past(evt_in.buf_read)})) else $error("buffer pair wrong");
  chk_rmw_level: assert property (!$past(wr_strobe_in) |->
    rmw_parity_enable_out == c2_q[POS_RMW_PARITY]) else $error("rmw parity level wrong");
  chk_beat_lat: assert property (first_beat_out ==
    (c3_q[23:20] inside {[4'h1:4'h5]} && sh_q[c3_q[22:20] - 3'h1])) else $error("first beat wrong");
  chk_act_hold: assert property (activate_allowed_out == (rc_q == 5'h0))
    else $error("activate hold-off wrong");
  chk_ras_width: assert property (ras_refresh_out == (rr_q != 5'h0))
    else $error("ras refresh width wrong");
  chk_page_close: assert property (precharge_cmd_out == ex_q)
    else $error("precharge timing wrong");
  chk_cas_start: assert property (evt_in.page_cycle_start && cas_ready_out && !sd |=>
    cas_active_out && !cas_ready_out) else $error("cas start wrong");
  cover property (evt_in.page_access && sd);
  cover property (precharge_cmd_out);
  cover property (evt_in.page_cycle_start && cas_ready_out);
endmodule
bind memory_timing_config mtc_chk u_chk (.*);

// ==== bench/mem_side_model.sv ====
/* far-side memory model: records the last cas assertion width and
   counts bank closes. assumes the slice's clock and reset. */
`timescale 1ns/10ps
module mem_side_model
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic cas_in,
  input  wire logic pre_in,
  output logic [4:0] cas_w_out,
  output logic [7:0] closes_out
);
  logic [4:0] run_q;
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      {run_q, cas_w_out, closes_out} <= '0;
    else
    begin
      run_q <= cas_in ? run_q + 5'h1 : 5'h0;
      if (!cas_in && run_q != 5'h0)
        cas_w_out <= run_q;
      if (pre_in)
        closes_out <= closes_out + 8'h1;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
/* self-checking bench: register port and core events driven here,
   memory side watched by mem_side_model. */
`timescale 1ns/10ps
module tb_top;
  import mem_timing_pkg::*;
  logic        clk_in, reset_n_in, ws, rs, ba, bb, rmw, pge, pre, act, fb, ras, cas, rdy;
  logic [7:0]  addr, closes;
  logic [31:0] wd, rdata, got, r;
  logic [4:0]  cas_w;
  logic [15:0] lf;
  logic [3:0]  cod [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  mem_evt_t    ev;
  int          fail_count, compares, first, cnt, n, p;
  memory_timing_config dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wr_data_in(wd),
    .wr_strobe_in(ws), .rd_strobe_in(rs), .rd_data_out(rdata), .evt_in(ev), .buffer_ctrl_a_out(ba),
    .buffer_ctrl_b_out(bb), .rmw_parity_enable_out(rmw), .parity_gen_enable_out(pge),
    .precharge_cmd_out(pre), .activate_allowed_out(act), .first_beat_out(fb),
    .ras_refresh_out(ras), .cas_active_out(cas), .cas_ready_out(rdy));
  mem_side_model mem (.clk_in(clk_in), .reset_n_in(reset_n_in), .cas_in(cas), .pre_in(pre),
    .cas_w_out(cas_w), .closes_out(closes));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic int d16(input logic [3:0] c);
    return (c == 4'h0) ? 16 : int'(c);
  endfunction
  function automatic int d8(input logic [2:0] c);
    return (c == 3'h0) ? 8 : int'(c);
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic sel(input int k);
    case (k)
      0: return fb;
      1: return !act;
      2: return ras;
      3: return pre;
      default: return rdy;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clk_in);
    ws <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk_in);
    rs <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic fire(input mem_evt_t b);
    @(posedge clk_in);
    ev <= b;
    @(posedge clk_in);
    ev <= '0;
  endtask
  task automatic meas(input int k, output int f, output int c);
    f = 0;
    c = 0;
    for (int i = 1; i <= 40; i++)
    begin
      #1;
      if (sel(k) === 1'b1 && f == 0)
        f = i;
      c += int'(sel(k) === 1'b1);
      @(posedge clk_in);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    summarize;
  end
  initial
  begin
    {reset_n_in, ws, rs, addr, wd} = '0;
    ev = '0;
    lf = 16'hc559;
    fail_count = 0;
    compares = 0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(OFF_CFG_TWO, got);
    chk("cfg_two reset", 32'h0000_0002, got);
    rd(8'h40, got);
    chk("unmapped read", 32'h0, got);
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr(lf);
      r = {lf, lfsr(lf)};
      r[23:20] = {2'b00, r[21:20]} + 4'h1;
      wr(OFF_CFG_THREE, r);
      rd(OFF_CFG_THREE, got);
      chk("cfg_three", r, got);
      r = r & MASK_CFG_TWO & ~32'h0002_0001;
      wr(OFF_CFG_TWO, r);
      rd(OFF_CFG_TWO, got);
      chk("cfg_two", r, got);
    end
    $display("test registers done");
    for (int m = 0; m < 2; m++)
    begin
      wr(OFF_CFG_TWO, 32'(1 - m) << POS_BUF_MODE);
      fire(8'h01);
      #1 chk("buffer read", (m == 0) ? 32'h3 : 32'h1, {30'h0, ba, bb});
      fire(8'h02);
      #1 chk("buffer write", (m == 0) ? 32'h1 : 32'h2, {30'h0, ba, bb});
    end
    wr(OFF_CFG_AUX, 32'h0000_0100);
    wr(OFF_CFG_TWO, 32'h0000_0003);
    repeat (2) @(posedge clk_in);
    #1 chk("rmw parity", 32'h3, {30'h0, rmw, pge});
    wr(OFF_CFG_TWO, 32'h0002_0002);
    repeat (2) @(posedge clk_in);
    #1 chk("ecc over parity", 32'h0, {30'h0, rmw, pge});
    $display("test buffer and parity done");
    wr(OFF_CFG_AUX, 32'h0000_0200);
    for (int l = 1; l <= 5; l++)
    begin
      wr(OFF_CFG_THREE, 32'(l) << POS_READ_LAT);
      fire(8'h20);
      meas(0, first, cnt);
      chk("read latency", l, first);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_CFG_AUX, 32'h0000_0200);
      wr(OFF_CFG_THREE, {4'h0, cod[i], 4'h1, 1'b0, cod[i], 15'h0});
      fire(8'h40);
      meas(1, first, cnt);
      chk("refresh hold-off", d16(cod[i]) - 1, cnt);
      wr(OFF_CFG_AUX, 32'h0000_0000);
      fire(8'h10);
      meas(2, first, cnt);
      chk("cbr ras width", d16(cod[i]), cnt);
    end
    $display("test latency and refresh done");
    wr(OFF_CFG_TWO, 32'h0000_0002); // ecc off for free cas timing
    for (int i = 0; i < 16; i++)
    begin
      lf = lfsr(lf);
      r = {8'h0, 4'h1, i[2], 4'h0, 1'b0, i[1:0], lf[2:0], 9'h0};
      wr(OFF_CFG_THREE, r);
      fire({4'h0, 1'b1, i[3], 2'b00});
      n = d8(r[14:12]);
      p = d8(r[11:9]);
      if (r[19] && i[3])
      begin
        n = (n > 1) ? n - 1 : 1;
        p++;
      end
      meas(4, first, cnt);
      chk("cas width", n, {27'h0, cas_w});
      chk("cas cycle", n + p + 1, first);
    end
    $display("test cas timing done");
    wr(OFF_CFG_THREE, 32'h1010_0000);
    for (int i = 0; i < 3; i++)
    begin
      lf = lfsr(lf);
      wr(OFF_CFG_AUX, {22'h0, 2'b10, 4'h0, lf[3:0]});
      fire(8'h80);
      repeat (3) @(posedge clk_in);
      fire(8'h80);
      meas(3, first, cnt);
      chk("page close", 18 + lf[3:0], first);
      chk("bank closes", i + 1, {24'h0, closes});
    end
    fire(8'h10);
    meas(2, first, cnt);
    chk("ras with sdram", 0, cnt);
    fire(8'h80);
    rd(OFF_STATUS, got);
    chk("status", 32'h1, got);
    wr(OFF_CFG_AUX, 32'h0);
    fire(8'h80);
    meas(3, first, cnt);
    chk("page without sdram", 0, cnt);
    $display("test open page done");
    summarize;
  end
endmodule
